/* File: core/frc_pkg.sv */
// Contract
// - Overcurrent response 00: keep running indefinitely with brick-wall current limiting.
// - Response 10: limit for the programmed delay, then follow the retry setting.
// - Response 11: disable output at once, then follow retry bits five to three.
// - Overcurrent retry 000: never restart until run cycled or power removed.
// - Retry 111: restart endlessly until commanded off, power lost, or other fault.
// - Restart attempts are spaced by the separate retry interval setting.
// - Overcurrent delay field counts 16 ms units, used only by delayed shutdown.
// - Every response sets the matching fault bit and asserts the alert line.
// - Fault bits hold until clear-faults, off-then-on command, or power cycle; the code also clears them when RUN rises with the on bit set.
// - Overtemperature sets none-of-above, status word MFR, MFR overtemp bit, alert.
// - Overtemperature response write of 00 or 01 raises a CML fault instead.
// - Overtemperature response 10 disables output immediately, then follows retry field.
// - Overtemperature response 11 holds output off only while the fault persists.
// - Overtemperature accepts only retry 000; other retry values raise a CML fault.
// - Overtemperature delay field is ignored whatever it holds.
// - Overcurrent sets none-of-above, IOUT_OC, status word IOUT, status IOUT bit, alert.
// - Overcurrent response byte is command 0x47, read/write, default 0x00.
package frc_pkg;

	localparam logic [7:0] CMD_OPERATION      = 8'h01;
	localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
	localparam logic [7:0] CMD_OC_ACTION      = 8'h47;
	localparam logic [7:0] CMD_STATUS_BYTE    = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD    = 8'h79;
	localparam logic [7:0] CMD_STATUS_IOUT    = 8'h7b;
	localparam logic [7:0] CMD_STATUS_CML     = 8'h7e;
	localparam logic [7:0] CMD_STATUS_MFR     = 8'h80;
	localparam logic [7:0] CMD_OT_ACTION      = 8'hd6;
	localparam logic [7:0] CMD_RETRY_INTERVAL = 8'hf5;

	localparam logic [7:0] OC_ACTION_RST      = 8'h00;
	localparam logic [7:0] OT_ACTION_RST      = 8'hc0;
	localparam logic [7:0] RETRY_INTERVAL_RST = 8'h0a;
	localparam logic [7:0] OPERATION_RST      = 8'h80;

	localparam int OP_ON_BIT   = 7;
	localparam int SB_NONE     = 0;
	localparam int SB_CML      = 1;
	localparam int SB_IOUT_OC  = 4;
	localparam int SW_MFR      = 12;
	localparam int SW_IOUT     = 14;
	localparam int SI_OC       = 7;
	localparam int SM_OT       = 6;
	localparam int SC_BAD_CMD  = 7;
	localparam int SC_BAD_DATA = 6;

	localparam logic [1:0] RESP_LIMIT = 2'b00;
	localparam logic [1:0] RESP_UNSUP = 2'b01;
	localparam logic [1:0] RESP_DELAY = 2'b10;
	localparam logic [1:0] RESP_SHUT  = 2'b11;
	localparam logic [1:0] OT_SHUT    = 2'b10;
	localparam logic [1:0] OT_HOLD    = 2'b11;
	localparam logic [2:0] RETRY_NONE    = 3'b000;
	localparam logic [2:0] RETRY_FOREVER = 3'b111;

	localparam int CLK_HZ           = 50_000_000;
	localparam int OC_DELAY_UNIT_MS = 16;
	localparam int RETRY_UNIT_MS    = 1;
	localparam int OC_UNIT_CYC      = OC_DELAY_UNIT_MS * (CLK_HZ / 1000);
	localparam int RETRY_UNIT_CYC   = RETRY_UNIT_MS * (CLK_HZ / 1000);
	localparam int CNT_W            = 24;

	typedef enum logic [2:0] {
		ST_OFF, ST_RUN, ST_LIMIT, ST_RETRY_WAIT, ST_OT_HOLD, ST_LATCHED
	} frc_state_t;

	typedef struct packed {
		logic       write;
		logic [7:0] code;
		logic [7:0] data;
	} frc_cmd_t;

	function automatic logic [1:0] frc_resp(input logic [7:0] b);
		return b[7:6];
	endfunction

	function automatic logic [2:0] frc_retry(input logic [7:0] b);
		return b[5:3];
	endfunction

	function automatic logic [2:0] frc_delay(input logic [7:0] b);
		return b[2:0];
	endfunction

endpackage : frc_pkg

/* File: core/frc_top.sv */
module frc_top
	import frc_pkg::*;
#(
	parameter int OC_UNIT_CYCLES    = OC_UNIT_CYC,
	parameter int RETRY_UNIT_CYCLES = RETRY_UNIT_CYC
) (
	input  wire logic        REF_CLK,
	input  wire logic        RESETN,
	input  wire logic        LINK_CLK,
	input  wire logic        CMD_VALID,
	input  wire logic        CMD_WRITE,
	input  wire logic [7:0]  CMD_CODE,
	input  wire logic [7:0]  CMD_WDATA,
	output logic             CMD_BUSY,
	output logic             RSP_VALID,
	output logic [15:0]      RSP_DATA,
	input  wire logic        OC_DETECT,
	input  wire logic        OT_DETECT,
	input  wire logic        RUN,
	output logic             OUTPUT_EN,
	output logic             CURRENT_LIMIT,
	output logic             ALERT_O,
	output logic             ALERT_OE
);

	if (OC_UNIT_CYCLES < 1 || RETRY_UNIT_CYCLES < 1 ||
		64'(OC_UNIT_CYCLES) * 64'd7 >= (64'd1 << CNT_W) ||
		64'(RETRY_UNIT_CYCLES) * 64'd255 >= (64'd1 << CNT_W)) begin : g_chk
		$error("frc_top: unit cycle parameters out of range");
	end

	localparam logic [CNT_W-1:0] OC_UNIT    = CNT_W'(OC_UNIT_CYCLES);
	localparam logic [CNT_W-1:0] RETRY_UNIT = CNT_W'(RETRY_UNIT_CYCLES);

	// Reset release, core domain
	logic rst_s1_r;
	logic rst_n;
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// Reset release, link domain
	logic lrst_s1_r;
	logic lrst_n;
	always_ff @(posedge LINK_CLK or negedge RESETN) begin
		if (!RESETN) begin
			lrst_s1_r <= 1'b0;
			lrst_n    <= 1'b0;
		end else begin
			lrst_s1_r <= 1'b1;
			lrst_n    <= lrst_s1_r;
		end
	end

	// Link side: capture command, toggle request, wait for acknowledge
	frc_cmd_t    cmd_hold_r;
	logic        req_tgl_r;
	logic        busy_r;
	logic        ack_s1_r;
	logic        ack_s2_r;
	logic        ack_seen_r;
	logic        rsp_valid_r;
	logic [15:0] rsp_data_r;
	logic        ack_tgl_r;
	logic [15:0] rd_data_r;
	wire         cmd_take = CMD_VALID && !busy_r;
	wire         ack_edge = ack_s2_r ^ ack_seen_r;

	always_ff @(posedge LINK_CLK or negedge lrst_n) begin
		if (!lrst_n) begin
			cmd_hold_r  <= '0;
			req_tgl_r   <= 1'b0;
			busy_r      <= 1'b0;
			ack_s1_r    <= 1'b0;
			ack_s2_r    <= 1'b0;
			ack_seen_r  <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 16'h0000;
		end else begin
			ack_s1_r    <= ack_tgl_r;
			ack_s2_r    <= ack_s1_r;
			ack_seen_r  <= ack_s2_r;
			rsp_valid_r <= ack_edge;
			if (cmd_take) begin
				cmd_hold_r <= '{write: CMD_WRITE, code: CMD_CODE, data: CMD_WDATA};
				req_tgl_r  <= ~req_tgl_r;
				busy_r     <= 1'b1;
			end else if (ack_edge) begin
				busy_r <= 1'b0;
			end
			if (ack_edge) begin
				rsp_data_r <= rd_data_r;
			end
		end
	end

	assign CMD_BUSY  = busy_r;
	assign RSP_VALID = rsp_valid_r;
	assign RSP_DATA  = rsp_data_r;

	// Core side: request sync and pin sync
	logic req_s1_r;
	logic req_s2_r;
	logic req_seen_r;
	logic oc_s1_r;
	logic oc_s2_r;
	logic ot_s1_r;
	logic ot_s2_r;
	logic run_s1_r;
	logic run_s2_r;
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_r   <= 1'b0;
			req_s2_r   <= 1'b0;
			req_seen_r <= 1'b0;
			oc_s1_r    <= 1'b0;
			oc_s2_r    <= 1'b0;
			ot_s1_r    <= 1'b0;
			ot_s2_r    <= 1'b0;
			run_s1_r   <= 1'b0;
			run_s2_r   <= 1'b0;
		end else begin
			req_s1_r   <= req_tgl_r;
			req_s2_r   <= req_s1_r;
			req_seen_r <= req_s2_r;
			oc_s1_r    <= OC_DETECT;
			oc_s2_r    <= oc_s1_r;
			ot_s1_r    <= OT_DETECT;
			ot_s2_r    <= ot_s1_r;
			run_s1_r   <= RUN;
			run_s2_r   <= run_s1_r;
		end
	end

	// Command decode
	wire        req_edge = req_s2_r ^ req_seen_r;
	wire        wr       = req_edge && cmd_hold_r.write;
	wire        rd       = req_edge && !cmd_hold_r.write;
	wire [7:0]  wdat     = cmd_hold_r.data;
	wire [7:0]  code     = cmd_hold_r.code;

	logic [7:0] oc_action_r;
	logic [7:0] ot_action_r;
	logic [7:0] retry_ival_r;
	logic [7:0] operation_r;
	logic       oc_flt_r;
	logic       ot_flt_r;
	logic       bad_cmd_r;
	logic       bad_data_r;
	logic       en_prev_r;

	wire wr_oc    = wr && code == CMD_OC_ACTION;
	wire wr_ot    = wr && code == CMD_OT_ACTION;
	wire wr_retry = wr && code == CMD_RETRY_INTERVAL;
	wire wr_op    = wr && code == CMD_OPERATION;
	wire wr_clr   = wr && code == CMD_CLEAR_FAULTS;
	wire oc_bad   = frc_resp(wdat) == RESP_UNSUP;
	wire ot_bad   = frc_resp(wdat) < OT_SHUT || frc_retry(wdat) != RETRY_NONE;
	wire rd_known = code == CMD_OPERATION || code == CMD_OC_ACTION || code == CMD_OT_ACTION ||
		code == CMD_RETRY_INTERVAL || code == CMD_STATUS_BYTE || code == CMD_STATUS_WORD ||
		code == CMD_STATUS_IOUT || code == CMD_STATUS_CML || code == CMD_STATUS_MFR;
	wire wr_known = wr_oc || wr_ot || wr_retry || wr_op || wr_clr;
	wire set_bad_cmd  = (wr && !wr_known) || (rd && !rd_known);
	wire set_bad_data = (wr_oc && oc_bad) || (wr_ot && ot_bad);

	// Enable and restart detection
	wire enable  = run_s2_r && operation_r[OP_ON_BIT];
	wire en_rise = enable && !en_prev_r;
	wire clr     = wr_clr || en_rise;

	// Status images
	wire        cml_any = bad_cmd_r || bad_data_r;
	wire [7:0]  st_byte = (8'(oc_flt_r || ot_flt_r) << SB_NONE) |
		(8'(cml_any) << SB_CML) | (8'(oc_flt_r) << SB_IOUT_OC);
	wire [15:0] st_word = {8'h00, st_byte} | (16'(oc_flt_r) << SW_IOUT) |
		(16'(ot_flt_r) << SW_MFR);
	wire [7:0]  st_iout = 8'(oc_flt_r) << SI_OC;
	wire [7:0]  st_mfr  = 8'(ot_flt_r) << SM_OT;
	wire [7:0]  st_cml  = (8'(bad_cmd_r) << SC_BAD_CMD) | (8'(bad_data_r) << SC_BAD_DATA);

	wire [15:0] rd_mux =
		code == CMD_OPERATION      ? {8'h00, operation_r} :
		code == CMD_OC_ACTION      ? {8'h00, oc_action_r} :
		code == CMD_OT_ACTION      ? {8'h00, ot_action_r} :
		code == CMD_RETRY_INTERVAL ? {8'h00, retry_ival_r} :
		code == CMD_STATUS_BYTE    ? {8'h00, st_byte} :
		code == CMD_STATUS_WORD    ? st_word :
		code == CMD_STATUS_IOUT    ? {8'h00, st_iout} :
		code == CMD_STATUS_CML     ? {8'h00, st_cml} :
		code == CMD_STATUS_MFR     ? {8'h00, st_mfr} : 16'h0000;

	// Fault response state machine
	frc_state_t       state_r;
	frc_state_t       state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [2:0]       retries_r;
	logic [2:0]       retries_nxt;

	wire [1:0]       oc_resp   = frc_resp(oc_action_r);
	wire [2:0]       oc_retry  = frc_retry(oc_action_r);
	wire [1:0]       ot_resp   = frc_resp(ot_action_r);
	wire [CNT_W-1:0] oc_dly    = CNT_W'(frc_delay(oc_action_r)) * OC_UNIT;
	wire [CNT_W-1:0] retry_dly = CNT_W'(retry_ival_r) * RETRY_UNIT;
	wire             ot_shut   = ot_s2_r && ot_resp == OT_SHUT;
	wire             ot_hold   = ot_s2_r && ot_resp == OT_HOLD;
	wire             retry_go  = oc_retry == RETRY_FOREVER ||
		(oc_retry != RETRY_NONE && retries_r != 3'b000);

	always_comb begin
		state_nxt   = state_r;
		cnt_nxt     = (cnt_r == '0) ? cnt_r : cnt_r - CNT_W'(1);
		retries_nxt = retries_r;
		case (state_r)
			ST_OFF: begin
				if (enable && !ot_s2_r) begin
					state_nxt   = ST_RUN;
					retries_nxt = oc_retry;
				end
			end
			ST_RUN, ST_LIMIT, ST_RETRY_WAIT: begin
				if (ot_shut) begin
					state_nxt = ST_LATCHED;
				end else if (ot_hold) begin
					state_nxt = ST_OT_HOLD;
				end else if (state_r == ST_RETRY_WAIT) begin
					if (cnt_r == '0) begin
						state_nxt = ST_RUN;
					end
				end else if (state_r == ST_LIMIT && !oc_s2_r) begin
					state_nxt = ST_RUN;
				end else if (oc_s2_r && state_r == ST_RUN && oc_resp == RESP_DELAY) begin
					state_nxt = ST_LIMIT;
					cnt_nxt   = oc_dly;
				end else if (oc_s2_r && ((state_r == ST_RUN && oc_resp == RESP_SHUT) ||
					(state_r == ST_LIMIT && cnt_r == '0))) begin
					if (retry_go) begin
						state_nxt = ST_RETRY_WAIT;
						cnt_nxt   = retry_dly;
						if (oc_retry != RETRY_FOREVER) begin
							retries_nxt = retries_r - 3'd1;
						end
					end else begin
						state_nxt = ST_LATCHED;
					end
				end
			end
			ST_OT_HOLD: begin
				if (!ot_s2_r) begin
					state_nxt = ST_RUN;
				end
			end
			ST_LATCHED: begin
				state_nxt = ST_LATCHED;
			end
			default: begin
				state_nxt = ST_OFF;
			end
		endcase
		if (!enable) begin
			state_nxt = ST_OFF;
		end
	end

	wire out_on_nxt = state_nxt == ST_RUN || state_nxt == ST_LIMIT;
	wire limit_nxt  = oc_s2_r && out_on_nxt &&
		(oc_resp == RESP_LIMIT || state_nxt == ST_LIMIT);

	logic out_en_r;
	logic limit_r;
	logic alert_r;
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= ST_OFF;
			cnt_r      <= '0;
			retries_r  <= 3'b000;
			out_en_r   <= 1'b0;
			limit_r    <= 1'b0;
			alert_r    <= 1'b0;
			en_prev_r  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			retries_r  <= retries_nxt;
			out_en_r   <= out_on_nxt;
			limit_r    <= limit_nxt;
			alert_r    <= oc_flt_r || ot_flt_r || cml_any;
			en_prev_r  <= enable;
		end
	end

	// Configuration and sticky flags; a set wins over a clear
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			oc_action_r  <= OC_ACTION_RST;
			ot_action_r  <= OT_ACTION_RST;
			retry_ival_r <= RETRY_INTERVAL_RST;
			operation_r  <= OPERATION_RST;
			oc_flt_r     <= 1'b0;
			ot_flt_r     <= 1'b0;
			bad_cmd_r    <= 1'b0;
			bad_data_r   <= 1'b0;
			rd_data_r    <= 16'h0000;
			ack_tgl_r    <= 1'b0;
		end else begin
			if (wr_oc && !oc_bad) begin
				oc_action_r <= wdat;
			end
			if (wr_ot && !ot_bad) begin
				ot_action_r <= wdat;
			end
			if (wr_retry) begin
				retry_ival_r <= wdat;
			end
			if (wr_op) begin
				operation_r <= wdat;
			end
			oc_flt_r   <= (oc_s2_r && out_en_r) || (oc_flt_r && !clr);
			ot_flt_r   <= ot_s2_r || (ot_flt_r && !clr);
			bad_cmd_r  <= set_bad_cmd || (bad_cmd_r && !clr);
			bad_data_r <= set_bad_data || (bad_data_r && !clr);
			if (req_edge) begin
				rd_data_r <= rd ? rd_mux : 16'h0000;
				ack_tgl_r <= ~ack_tgl_r;
			end
		end
	end

	assign OUTPUT_EN     = out_en_r;
	assign CURRENT_LIMIT = limit_r;
	assign ALERT_O       = 1'b0;
	assign ALERT_OE      = alert_r;

endmodule : frc_top

/* File: tb/frc_top_assertions.sv */
module frc_checker
	import frc_pkg::*;
#(
	parameter int OC_UNIT_CYCLES    = OC_UNIT_CYC,
	parameter int RETRY_UNIT_CYCLES = RETRY_UNIT_CYC
) (
	input wire logic        REF_CLK,
	input wire logic        RESETN,
	input wire logic        LINK_CLK,
	input wire logic        CMD_VALID,
	input wire logic        CMD_WRITE,
	input wire logic [7:0]  CMD_CODE,
	input wire logic [7:0]  CMD_WDATA,
	input wire logic        CMD_BUSY,
	input wire logic        RSP_VALID,
	input wire logic [15:0] RSP_DATA,
	input wire logic        OC_DETECT,
	input wire logic        OT_DETECT,
	input wire logic        RUN,
	input wire logic        OUTPUT_EN,
	input wire logic        CURRENT_LIMIT,
	input wire logic        ALERT_O,
	input wire logic        ALERT_OE
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [5:0] quiet_r;
	logic [5:0] quiet_nxt;

	// Cycles since the last command or run-low
	assign quiet_nxt = (CMD_VALID || !RUN) ? 6'h00 : quiet_r + {5'h00, quiet_r != 6'h3f};
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN)
			quiet_r <= 6'h00;
		else
			quiet_r <= quiet_nxt;
	end

	sequence s_oc_seen;
		(OC_DETECT && OUTPUT_EN) [*3];
	endsequence
	sequence s_take;
		CMD_VALID && !CMD_BUSY;
	endsequence

	a_oc_alert: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_oc_seen |-> ##[0:5] ALERT_OE) else $error("alert missing after overcurrent");
	a_ot_alert: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		OT_DETECT [*4] |-> ##[0:3] ALERT_OE) else $error("alert missing after overtemp");
	a_alert_sticky: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		$fell(ALERT_OE) |-> quiet_r < 6'h28) else $error("alert dropped without clear");
	a_limit_when_on: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		$rose(CURRENT_LIMIT) |-> OUTPUT_EN) else $error("limiting while output off");
	a_run_low_off: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		!RUN [*5] |-> !OUTPUT_EN) else $error("output on while run low");
	a_ot_output_off: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		OT_DETECT [*6] |-> !OUTPUT_EN) else $error("output on during overtemp");
	a_busy_on_take: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
		s_take |=> CMD_BUSY) else $error("busy not raised after take");
	a_rsp_bounded: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
		s_take |-> ##[2:10] RSP_VALID) else $error("response late");
	a_rsp_pulse: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
		RSP_VALID |=> !RSP_VALID) else $error("response longer than one cycle");
endmodule // frc_checker

bind frc_top frc_checker #(
	.OC_UNIT_CYCLES(OC_UNIT_CYCLES), .RETRY_UNIT_CYCLES(RETRY_UNIT_CYCLES)
) i_frc_checker (
	.REF_CLK(REF_CLK), .RESETN(RESETN), .LINK_CLK(LINK_CLK), .CMD_VALID(CMD_VALID),
	.CMD_WRITE(CMD_WRITE), .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .CMD_BUSY(CMD_BUSY),
	.RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .OC_DETECT(OC_DETECT), .OT_DETECT(OT_DETECT),
	.RUN(RUN), .OUTPUT_EN(OUTPUT_EN), .CURRENT_LIMIT(CURRENT_LIMIT), .ALERT_O(ALERT_O),
	.ALERT_OE(ALERT_OE)
);

/* File: tb/frc_host_model.sv */
module frc_host_model
	import frc_pkg::*;
(
	input  wire logic        link_clk,
	input  wire logic        cmd_busy,
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data,
	output logic             cmd_valid,
	output frc_cmd_t         cmd
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cmd_valid = 1'b0;
		cmd = '{write: 1'b0, code: 8'h00, data: 8'h00};
	end

	// One command outstanding, held until the taking edge
	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
		output logic [15:0] r, output logic ok);
		int n;
		ok = 1'b0;
		r = 16'h0000;
		@(posedge link_clk);
		cmd_valid <= 1'b1;
		cmd <= '{write: w, code: c, data: d};
		@(posedge link_clk);
		cmd_valid <= 1'b0;
		cmd <= ~cmd;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge link_clk);
			if (rsp_valid === 1'b1) begin
				r = rsp_data;
				ok = 1'b1;
			end
		end
	endtask
endmodule // frc_host_model

/* File: tb/testbench.sv */
module testbench
	import frc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        ref_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        oc_det = 1'b0;
	logic        ot_det = 1'b0;
	logic        run = 1'b1;
	logic        cmd_valid;
	frc_cmd_t    cmd;
	logic        cmd_busy, rsp_valid, out_en, cur_lim, alert_o, alert_oe;
	logic [15:0] rsp_data;
	logic [15:0] bad [5] = '{16'hd600, 16'hd640, 16'hd688, 16'hd6f8, 16'h4740};
	int          num_errors = 0;
	int          cmp_count = 0;

	always #10 ref_clk = ~ref_clk;
	always begin
		#3.7;
		forever #80 link_clk = ~link_clk;
	end

	frc_top #(.OC_UNIT_CYCLES(4), .RETRY_UNIT_CYCLES(3)) i_frc_top (
		.REF_CLK(ref_clk), .RESETN(resetn), .LINK_CLK(link_clk), .CMD_VALID(cmd_valid),
		.CMD_WRITE(cmd.write), .CMD_CODE(cmd.code), .CMD_WDATA(cmd.data), .CMD_BUSY(cmd_busy),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .OC_DETECT(oc_det), .OT_DETECT(ot_det),
		.RUN(run), .OUTPUT_EN(out_en), .CURRENT_LIMIT(cur_lim), .ALERT_O(alert_o),
		.ALERT_OE(alert_oe)
	);
	frc_host_model i_frc_host_model (
		.link_clk(link_clk), .cmd_busy(cmd_busy), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd(cmd)
	);

	task automatic report_and_stop;
		$display("Comparisons %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Pins as {output enable, current limit, alert}
	task automatic chk(input logic [2:0] e);
		@(negedge ref_clk);
		cmp({12'h000, alert_o, out_en, cur_lim, alert_oe}, {13'h0000, e});
	endtask

	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
		output logic [15:0] r);
		logic ok;
		i_frc_host_model.xfer(w, c, d, r, ok);
		if (ok !== 1'b1) begin
			num_errors++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		logic [15:0] r;
		xfer(1'b1, c, d, r);
	endtask

	task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic [15:0] m = 16'hffff);
		logic [15:0] r;
		xfer(1'b0, c, 8'h00, r);
		cmp(r & m, e);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Pins as {overcurrent, overtemp, run}
	task automatic pins(input logic [2:0] p);
		@(posedge ref_clk);
		oc_det <= p[2];
		ot_det <= p[1];
		run <= p[0];
	endtask

	task automatic run_cycle;
		pins(3'b000);
		tick(6);
		pins(3'b001);
		tick(8);
	endtask

	task automatic count_rises(input int cyc, output int n);
		logic prev;
		prev = out_en;
		n = 0;
		repeat (cyc) begin
			@(negedge ref_clk);
			if (out_en === 1'b1 && prev !== 1'b1)
				n++;
			prev = out_en;
		end
	endtask

	task automatic off_len(output int n);
		n = 0;
		while (out_en !== 1'b0 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		n = 0;
		while (out_en !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		if (out_en !== 1'b1 || n == 0) begin
			num_errors++;
			report_and_stop();
		end
	endtask

	initial begin
		int i;
		int n;
		tick(6);
		resetn <= 1'b1;
		repeat (4) @(posedge link_clk);
		rd(CMD_OC_ACTION, 16'h0000);
		rd(CMD_OT_ACTION, 16'h00c0);
		rd(CMD_RETRY_INTERVAL, 16'h000a);
		chk(3'b100);
		pins(3'b101);
		tick(12);
		chk(3'b111);
		rd(CMD_STATUS_BYTE, 16'h0011);
		rd(CMD_STATUS_WORD, 16'h4000, 16'h4000);
		rd(CMD_STATUS_IOUT, 16'h0080);
		pins(3'b001);
		tick(6);
		chk(3'b101);
		wr(CMD_CLEAR_FAULTS, 8'h00);
		chk(3'b100);
		wr(CMD_OC_ACTION, 8'hc0);
		pins(3'b101);
		tick(6);
		chk(3'b001);
		pins(3'b001);
		tick(60);
		chk(3'b001);
		wr(CMD_CLEAR_FAULTS, 8'h00);
		chk(3'b000);
		run_cycle;
		chk(3'b100);
		wr(CMD_OC_ACTION, 8'h82);
		pins(3'b101);
		tick(9);
		chk(3'b111);
		tick(6);
		chk(3'b001);
		run_cycle;
		wr(CMD_OC_ACTION, 8'hf8);
		pins(3'b101);
		off_len(n);
		cmp({15'h0000, n >= 28 && n <= 40}, 16'h0001);
		count_rises(300, n);
		cmp({15'h0000, n > 6}, 16'h0001);
		pins(3'b000);
		wr(CMD_OC_ACTION, 8'hd0);
		pins(3'b101);
		count_rises(400, n);
		cmp(n[15:0], 16'h0003);
		chk(3'b001);
		run_cycle;
		wr(CMD_CLEAR_FAULTS, 8'h00);
		pins(3'b011);
		tick(6);
		chk(3'b001);
		rd(CMD_STATUS_BYTE, 16'h0001);
		rd(CMD_STATUS_WORD, 16'h1000, 16'h1000);
		rd(CMD_STATUS_MFR, 16'h0040);
		pins(3'b001);
		tick(8);
		chk(3'b101);
		wr(CMD_CLEAR_FAULTS, 8'h00);
		wr(CMD_OT_ACTION, 8'h87);
		rd(CMD_OT_ACTION, 16'h0087);
		pins(3'b011);
		tick(6);
		chk(3'b001);
		pins(3'b001);
		tick(60);
		chk(3'b001);
		run_cycle;
		wr(CMD_CLEAR_FAULTS, 8'h00);
		for (i = 0; i < 5; i++) begin
			wr(bad[i][15:8], bad[i][7:0]);
			rd(CMD_STATUS_CML, 16'h0040);
			wr(CMD_CLEAR_FAULTS, 8'h00);
		end
		rd(CMD_OT_ACTION, 16'h0087);
		rd(CMD_OC_ACTION, 16'h00d0);
		wr(8'h55, 8'h00);
		rd(CMD_STATUS_CML, 16'h0080);
		wr(CMD_RETRY_INTERVAL, 8'h05);
		rd(CMD_RETRY_INTERVAL, 16'h0005);
		wr(CMD_OC_ACTION, 8'hf8);
		pins(3'b101);
		off_len(n);
		cmp({15'h0000, n >= 14 && n <= 18}, 16'h0001);
		pins(3'b001);
		wr(CMD_OPERATION, 8'h00);
		chk(3'b001);
		wr(CMD_OPERATION, 8'h80);
		chk(3'b100);
		rd(CMD_OPERATION, 16'h0080);
		report_and_stop;
	end
endmodule // testbench
